/* File: rtl/plpc_cfg.svh */
`ifndef PLPC_CFG_SVH
`define PLPC_CFG_SVH

// ============================================================
// Register offsets (byte addresses)
`define PLPC_OFS_CTRL 12'h000
`define PLPC_OFS_STATUS 12'h004
`define PLPC_OFS_EVENT 12'h008
`define PLPC_OFS_DEBOUNCE 12'h00C

// ============================================================
// Control fields and reset values
`define PLPC_CTRL_ENABLE 0
`define PLPC_CTRL_QR_OPTION 1
`define PLPC_CTRL_RESET 2'h1

// ============================================================
// Status fields
`define PLPC_ST_GATE 0
`define PLPC_ST_OCP_LO 1
`define PLPC_ST_OCP_HI 2
`define PLPC_ST_SHUTDOWN 3
`define PLPC_ST_THERMAL 4
`define PLPC_ST_PFC_CLOSED 5
`define PLPC_ST_UVLO_LOW 6
`define PLPC_ST_BURST 7
`define PLPC_ST_FF_OVER 8
`define PLPC_ST_HV_ON 9

// ============================================================
// Sticky event fields, write one to clear
`define PLPC_EV_HARD_OCP 0
`define PLPC_EV_SHUTDOWN 1
`define PLPC_EV_PFC_OPEN 2
`define PLPC_EV_WIDTH 3

// ============================================================
// Synchroniser lane positions
`define PLPC_IN_OSC_TICK 0
`define PLPC_IN_VALLEY 1
`define PLPC_IN_PWM_CMP 2
`define PLPC_IN_OCP_CMP 3
`define PLPC_IN_HARD_OCP 4
`define PLPC_IN_FF_OVER 5
`define PLPC_IN_COMP_CLAMP 6
`define PLPC_IN_VCC_UVLO 7
`define PLPC_IN_VCC_NORMAL 8
`define PLPC_IN_VCC_RESTART 9
`define PLPC_IN_COMP_PFC_OFF 10
`define PLPC_IN_COMP_PFC_ON 11
`define PLPC_IN_COMP_BURST 12
`define PLPC_IN_PFC_THERMAL 13
`define PLPC_IN_WIDTH 14

// ============================================================
// Oscillator cycles the control voltage must stay low
`define PLPC_PFC_DEBOUNCE 1024
`define PLPC_CNT_WIDTH 11

`endif

/* File: rtl/plpc_ctrl.sv */
`timescale 1ns/1ps
`include "plpc_cfg.svh"

module plpc_ctrl #(
  parameter int PFC_DEBOUNCE = `PLPC_PFC_DEBOUNCE
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Analog comparators and oscillator, asynchronous
  input wire logic osc_tick_in,
  input wire logic valley_trigger_in,
  input wire logic pwm_cmp_in,
  input wire logic ocp_cmp_in,
  input wire logic hard_ocp_cmp_in,
  input wire logic ff_over_3v_in,
  input wire logic comp_low_clamp_in,
  input wire logic vcc_above_uvlo_in,
  input wire logic vcc_above_normal_in,
  input wire logic vcc_below_restart_in,
  input wire logic comp_below_pfc_off_in,
  input wire logic comp_above_pfc_on_in,
  input wire logic comp_below_burst_in,
  input wire logic pfc_switch_thermal_in,
  // Controls toward the power stage
  output logic gate_out,
  output logic line_feedforward_ground_out,
  output logic pfc_supply_switch_close_out,
  output logic uvlo_low_sel_out,
  output logic hv_startup_on_out,
  output logic quasi_resonant_option_out,
  output logic low_power_out
);

  // ============================================================
  // Synchronised inputs
  logic [`PLPC_IN_WIDTH-1:0] raw;
  logic [`PLPC_IN_WIDTH-1:0] syn;

  assign raw = {pfc_switch_thermal_in, comp_below_burst_in,
                comp_above_pfc_on_in, comp_below_pfc_off_in,
                vcc_below_restart_in, vcc_above_normal_in,
                vcc_above_uvlo_in, comp_low_clamp_in, ff_over_3v_in,
                hard_ocp_cmp_in, ocp_cmp_in, pwm_cmp_in,
                valley_trigger_in, osc_tick_in};

  // All comparator levels cross two flops first
  plpc_sync #(.WIDTH(`PLPC_IN_WIDTH)) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in(raw),
    .sync_out(syn)
  );

  logic osc_s;
  logic valley_s;
  logic pwm_s;
  logic ocp_s;
  logic hard_s;
  logic ff_over_s;
  logic clamp_s;
  logic uvlo_ok_s;
  logic normal_s;
  logic restart_s;
  logic pfc_off_s;
  logic pfc_on_s;
  logic burst_s;
  logic thermal_s;

  assign osc_s = syn[`PLPC_IN_OSC_TICK];
  assign valley_s = syn[`PLPC_IN_VALLEY];
  assign pwm_s = syn[`PLPC_IN_PWM_CMP];
  assign ocp_s = syn[`PLPC_IN_OCP_CMP];
  assign hard_s = syn[`PLPC_IN_HARD_OCP];
  assign ff_over_s = syn[`PLPC_IN_FF_OVER];
  assign clamp_s = syn[`PLPC_IN_COMP_CLAMP];
  assign uvlo_ok_s = syn[`PLPC_IN_VCC_UVLO];
  assign normal_s = syn[`PLPC_IN_VCC_NORMAL];
  assign restart_s = syn[`PLPC_IN_VCC_RESTART];
  assign pfc_off_s = syn[`PLPC_IN_COMP_PFC_OFF];
  assign pfc_on_s = syn[`PLPC_IN_COMP_PFC_ON];
  assign burst_s = syn[`PLPC_IN_COMP_BURST];
  assign thermal_s = syn[`PLPC_IN_PFC_THERMAL];

  // ============================================================
  // Edge detection on the synchronised side only
  logic osc_d;
  logic valley_d;
  logic hard_d;
  logic burst_d;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_d <= 1'b0;
      valley_d <= 1'b0;
      hard_d <= 1'b0;
      burst_d <= 1'b0;
    end else begin
      osc_d <= osc_s;
      valley_d <= valley_s;
      hard_d <= hard_s;
      burst_d <= burst_s;
    end
  end

  logic tick;
  logic valley_evt;
  logic hard_evt;
  logic burst_entry;

  assign tick = osc_s && !osc_d;
  assign valley_evt = valley_s && !valley_d;
  assign hard_evt = hard_s && !hard_d;
  assign burst_entry = burst_s && !burst_d;

  // ============================================================
  // Software control
  logic [1:0] ctrl;
  logic sw_enable;
  logic qr_mode;

  assign sw_enable = ctrl[`PLPC_CTRL_ENABLE];
  assign qr_mode = ctrl[`PLPC_CTRL_QR_OPTION];

  // ============================================================
  // Hard overcurrent hiccup machine
  plpc_pkg::plpc_ocp_state_t ocp_state;
  plpc_pkg::plpc_ocp_state_t next_ocp_state;

  // Warning spans the rest of this cycle plus one whole cycle,
  // so the stop lands on the second or third detection
  always_comb begin
    next_ocp_state = ocp_state;
    unique case (ocp_state)
      plpc_pkg::OCP_IDLE: begin
        if (hard_evt) begin
          next_ocp_state = plpc_pkg::OCP_WARN_REST;
        end
      end
      plpc_pkg::OCP_WARN_REST: begin
        if (tick) begin
          next_ocp_state = plpc_pkg::OCP_WARN_NEXT;
        end
      end
      plpc_pkg::OCP_WARN_NEXT: begin
        if (hard_evt) begin
          next_ocp_state = plpc_pkg::OCP_SHUT;
        end else if (tick) begin
          next_ocp_state = plpc_pkg::OCP_IDLE;
        end
      end
      plpc_pkg::OCP_SHUT: begin
        if (!uvlo_ok_s) begin
          next_ocp_state = plpc_pkg::OCP_IDLE;
        end
      end
    endcase
    if (!uvlo_ok_s) begin
      next_ocp_state = plpc_pkg::OCP_IDLE;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ocp_state <= plpc_pkg::OCP_IDLE;
    end else begin
      ocp_state <= next_ocp_state;
    end
  end

  logic ocp_shut;
  assign ocp_shut = (ocp_state == plpc_pkg::OCP_SHUT);

  // ============================================================
  // Thermal trip of the PFC supply switch, latched while supplied
  logic thermal_latch;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      thermal_latch <= 1'b0;
    end else if (!uvlo_ok_s) begin
      thermal_latch <= 1'b0;
    end else if (thermal_s) begin
      thermal_latch <= 1'b1;
    end
  end

  logic latched_prot;
  assign latched_prot = ocp_shut || thermal_latch;

  // ============================================================
  // Start-up generator: once a latch has been dropped by UVLO,
  // stay off until Vcc falls to the restart level
  logic hv_hold;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hv_hold <= 1'b0;
    end else if (latched_prot && !uvlo_ok_s) begin
      hv_hold <= 1'b1;
    end else if (restart_s) begin
      hv_hold <= 1'b0;
    end
  end

  // Generator charges Vcc only while below UVLO and not held
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hv_startup_on_out <= 1'b0;
    end else begin
      hv_startup_on_out <= !uvlo_ok_s && !hv_hold &&
                           !(latched_prot && !uvlo_ok_s);
    end
  end

  // ============================================================
  // Switching permission
  logic run;
  assign run = sw_enable && uvlo_ok_s && !latched_prot &&
               !ff_over_s &&
               !burst_s;

  // ============================================================
  // PWM latch: reset wins over set in the same cycle
  logic set_evt;
  logic clr_evt;

  assign set_evt = tick || (qr_mode && valley_evt);
  assign clr_evt = pwm_s || ocp_s;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gate_out <= 1'b0;
    end else if (!run || clr_evt) begin
      gate_out <= 1'b0;
    end else if (set_evt) begin
      gate_out <= 1'b1;
    end
  end

  // Consumption drops while burst mode holds switching off
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      low_power_out <= 1'b0;
    end else begin
      low_power_out <= burst_s || latched_prot;
    end
  end

  // Feedforward pin forced low under these three causes
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      line_feedforward_ground_out <= 1'b1;
    end else begin
      line_feedforward_ground_out <= !uvlo_ok_s || latched_prot ||
                                     clamp_s;
    end
  end

  // ============================================================
  // PFC supply switch with hysteresis and debounce
  logic [`PLPC_CNT_WIDTH-1:0] dbn_count;
  logic dbn_expired;

  plpc_tick_cnt #(
    .WIDTH(`PLPC_CNT_WIDTH),
    .LIMIT(PFC_DEBOUNCE)
  ) u_dbn (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .hold_in(pfc_off_s),
    .tick_in(tick),
    .count_out(dbn_count),
    .expired_out(dbn_expired)
  );

  logic pfc_open_evt;
  assign pfc_open_evt = pfc_supply_switch_close_out &&
                        (burst_entry || dbn_expired || thermal_s);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pfc_supply_switch_close_out <= 1'b1;
    end else if (thermal_s || thermal_latch) begin
      pfc_supply_switch_close_out <= 1'b0;
    end else if (burst_entry) begin
      pfc_supply_switch_close_out <= 1'b0;
    end else if (dbn_expired) begin
      pfc_supply_switch_close_out <= 1'b0;
    end else if (pfc_on_s) begin
      pfc_supply_switch_close_out <= 1'b1;
    end
  end

  // Threshold pair follows the operating option
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      quasi_resonant_option_out <= 1'b0;
    end else begin
      quasi_resonant_option_out <= qr_mode;
    end
  end

  // ============================================================
  // Adaptive UVLO threshold select
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      uvlo_low_sel_out <= 1'b0;
    end else if (pfc_off_s) begin
      uvlo_low_sel_out <= 1'b1;
    end else if (pfc_on_s && normal_s) begin
      uvlo_low_sel_out <= 1'b0;
    end
  end

  // ============================================================
  // APB slave, zero wait states
  logic setup;
  logic access;
  logic wr_fire;
  logic addr_ok;

  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in && pready_out;
  assign wr_fire = access && pwrite_in;

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == `PLPC_OFS_CTRL) || (a == `PLPC_OFS_STATUS) ||
                 (a == `PLPC_OFS_EVENT) || (a == `PLPC_OFS_DEBOUNCE);
  endfunction

  assign addr_ok = known_addr(paddr_in);

  // Control register steers the latch and thresholds
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= `PLPC_CTRL_RESET;
    end else if (wr_fire && paddr_in == `PLPC_OFS_CTRL) begin
      ctrl <= pwdata_in[1:0];
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  logic [`PLPC_EV_WIDTH-1:0] events;
  logic [`PLPC_EV_WIDTH-1:0] ev_set;
  logic [`PLPC_EV_WIDTH-1:0] ev_clr;

  assign ev_set = {pfc_open_evt,
                   next_ocp_state == plpc_pkg::OCP_SHUT && !ocp_shut,
                   hard_evt};
  assign ev_clr = (wr_fire && paddr_in == `PLPC_OFS_EVENT) ?
                  pwdata_in[`PLPC_EV_WIDTH-1:0] : '0;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      events <= '0;
    end else begin
      events <= (events & ~ev_clr) | ev_set;
    end
  end

  // Live status word
  logic [31:0] status;
  always_comb begin
    status = '0;
    status[`PLPC_ST_GATE] = gate_out;
    status[`PLPC_ST_OCP_HI:`PLPC_ST_OCP_LO] = ocp_state;
    status[`PLPC_ST_SHUTDOWN] = ocp_shut;
    status[`PLPC_ST_THERMAL] = thermal_latch;
    status[`PLPC_ST_PFC_CLOSED] = pfc_supply_switch_close_out;
    status[`PLPC_ST_UVLO_LOW] = uvlo_low_sel_out;
    status[`PLPC_ST_BURST] = burst_s;
    status[`PLPC_ST_FF_OVER] = ff_over_s;
    status[`PLPC_ST_HV_ON] = hv_startup_on_out;
  end

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= '0;
    end else if (setup && !pwrite_in) begin
      unique case (paddr_in)
        `PLPC_OFS_CTRL: prdata_out <= {30'h0, ctrl};
        `PLPC_OFS_STATUS: prdata_out <= status;
        `PLPC_OFS_EVENT: prdata_out <= {29'h0, events};
        `PLPC_OFS_DEBOUNCE: prdata_out <= {21'h0, dbn_count};
        default: prdata_out <= '0;
      endcase
    end
  end

  // Ready for exactly the first access cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= setup;
      pslverr_out <= setup && !addr_ok;
    end
  end

endmodule // plpc_ctrl

/* File: rtl/plpc_pkg.sv */
// ============================================================
// Types shared by the latch and protection control
package plpc_pkg;

  // Hard overcurrent protection states
  typedef enum logic [1:0] {
    OCP_IDLE,
    OCP_WARN_REST,
    OCP_WARN_NEXT,
    OCP_SHUT
  } plpc_ocp_state_t;

endpackage

/* File: rtl/plpc_sync.sv */
`timescale 1ns/1ps

// ============================================================
// Two-flop synchroniser for a group of level inputs
module plpc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // plpc_sync

/* File: rtl/plpc_tick_cnt.sv */
`timescale 1ns/1ps
`include "plpc_cfg.svh"

// ============================================================
// Counts oscillator ticks while a condition holds
module plpc_tick_cnt #(
  parameter int WIDTH = `PLPC_CNT_WIDTH,
  parameter int LIMIT = `PLPC_PFC_DEBOUNCE
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic hold_in,
  input wire logic tick_in,
  output logic [WIDTH-1:0] count_out,
  output logic expired_out
);

  localparam logic [WIDTH-1:0] TOP = WIDTH'(LIMIT + 1);

  // Restart on release; saturate past the limit
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out <= '0;
    end else if (!hold_in) begin
      count_out <= '0;
    end else if (tick_in && count_out != TOP) begin
      count_out <= count_out + WIDTH'(1);
    end
  end

  // Expiry means strictly more than the limit
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      expired_out <= 1'b0;
    end else begin
      expired_out <= hold_in && (count_out == TOP);
    end
  end

endmodule // plpc_tick_cnt

/* File: tb/plpc_ctrl_monitor.sv */
`timescale 1ns/1ps

// ============================================================
// Port checker for the latch and protection control
module plpc_ctrl_monitor #(
  parameter int PFC_DEBOUNCE = 1024
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic osc_tick_in,
  input wire logic valley_trigger_in,
  input wire logic pwm_cmp_in,
  input wire logic ocp_cmp_in,
  input wire logic hard_ocp_cmp_in,
  input wire logic ff_over_3v_in,
  input wire logic vcc_above_uvlo_in,
  input wire logic vcc_above_normal_in,
  input wire logic comp_below_pfc_off_in,
  input wire logic comp_above_pfc_on_in,
  input wire logic comp_below_burst_in,
  input wire logic pfc_switch_thermal_in,
  input wire logic gate_out,
  input wire logic line_feedforward_ground_out,
  input wire logic pfc_supply_switch_close_out,
  input wire logic uvlo_low_sel_out,
  input wire logic low_power_out
);
  logic tick_q;
  logic hard_q;
  logic cause;
  int low_cnt;
  int hits;
  wire set_src = osc_tick_in | valley_trigger_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Counts raw ticks, ahead of the synchronised copy, so it already
  // holds the opening tick when the switch drops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_q <= 1'b0;
      low_cnt <= 0;
    end else begin
      tick_q <= osc_tick_in;
      if (!comp_below_pfc_off_in) begin
        low_cnt <= 0;
      end else if (osc_tick_in && !tick_q) begin
        low_cnt <= low_cnt + 1;
      end
    end
  end

  // Other stop causes, and hard detections within one supply run
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hard_q <= 1'b0;
      cause <= 1'b0;
      hits <= 0;
    end else begin
      hard_q <= hard_ocp_cmp_in;
      if (comp_below_burst_in || pfc_switch_thermal_in) begin
        cause <= 1'b1;
      end else if (comp_above_pfc_on_in) begin
        cause <= 1'b0;
      end
      if (!vcc_above_uvlo_in) begin
        hits <= 0;
      end else if (hard_ocp_cmp_in && !hard_q) begin
        hits <= hits + 1;
      end
    end
  end

  sequence burst_held;
    (comp_below_burst_in && !comp_above_pfc_on_in)[*5];
  endsequence

  gate_clear_a: assert property (
    (pwm_cmp_in || ocp_cmp_in)[*4] |-> !gate_out)
    else $error("gate left on after a clear");
  gate_set_a: assert property (
    $rose(gate_out) |-> $past(set_src, 2) || $past(set_src, 3))
    else $error("gate rose without a set event");
  run_stop_a: assert property (
    (ff_over_3v_in || comp_below_burst_in)[*5] |-> !gate_out)
    else $error("gate on while switching is stopped");
  ff_ground_a: assert property (
    (!vcc_above_uvlo_in)[*5] |-> line_feedforward_ground_out)
    else $error("feedforward not grounded in lockout");
  shut_two_a: assert property (
    $rose(low_power_out) && !cause |-> hits >= 2)
    else $error("stop before a second hard detection");
  pfc_debounce_a: assert property (
    $fell(pfc_supply_switch_close_out) && !cause |->
      low_cnt > PFC_DEBOUNCE)
    else $error("supply switch opened early");
  burst_open_a: assert property (
    burst_held |-> !pfc_supply_switch_close_out && low_power_out)
    else $error("burst did not open switch");
  pfc_reclose_a: assert property (
    $rose(pfc_supply_switch_close_out) |->
      $past(comp_above_pfc_on_in, 3))
    else $error("switch closed below on threshold");
  uvlo_low_a: assert property (
    comp_below_pfc_off_in[*5] |-> uvlo_low_sel_out)
    else $error("lower lockout not selected");
endmodule // plpc_ctrl_monitor

bind plpc_ctrl plpc_ctrl_monitor #(.PFC_DEBOUNCE(PFC_DEBOUNCE)) u_mon (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .osc_tick_in(osc_tick_in),
  .valley_trigger_in(valley_trigger_in), .pwm_cmp_in(pwm_cmp_in),
  .ocp_cmp_in(ocp_cmp_in), .hard_ocp_cmp_in(hard_ocp_cmp_in),
  .ff_over_3v_in(ff_over_3v_in), .vcc_above_uvlo_in(vcc_above_uvlo_in),
  .vcc_above_normal_in(vcc_above_normal_in),
  .comp_below_pfc_off_in(comp_below_pfc_off_in),
  .comp_above_pfc_on_in(comp_above_pfc_on_in),
  .comp_below_burst_in(comp_below_burst_in),
  .pfc_switch_thermal_in(pfc_switch_thermal_in), .gate_out(gate_out),
  .line_feedforward_ground_out(line_feedforward_ground_out),
  .pfc_supply_switch_close_out(pfc_supply_switch_close_out),
  .uvlo_low_sel_out(uvlo_low_sel_out), .low_power_out(low_power_out)
);

/* File: tb/plpc_stage_model.sv */
`timescale 1ns/1ps

// ============================================================
// Current sense stand-in for the power stage
module plpc_stage_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic gate_in,
  input wire logic [7:0] on_cycles_in,
  output logic pwm_cmp_out
);
  logic [7:0] ramp;

  // Current builds only while the switch conducts; a long setting
  // lets the cycle limit trip first
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ramp <= 8'h00;
    end else if (!gate_in) begin
      ramp <= 8'h00;
    end else if (ramp != 8'hFF) begin
      ramp <= ramp + 8'h01;
    end
  end

  // No current, no trip
  assign pwm_cmp_out = gate_in && (ramp >= on_cycles_in);
endmodule // plpc_stage_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "plpc_cfg.svh"

// ============================================================
// Register-level bench for the latch and protection control
module tb_top;
  localparam int DEB = 4;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out, rdata;
  logic pready_out, pslverr_out, pwm_cmp_in, rerr, g;
  logic osc_tick_in = 1'b0, valley_trigger_in = 1'b0, ocp_cmp_in = 1'b0;
  logic hard_ocp_cmp_in = 1'b0, ff_over_3v_in = 1'b0;
  logic comp_low_clamp_in = 1'b0, vcc_above_uvlo_in = 1'b0;
  logic vcc_above_normal_in = 1'b0, vcc_below_restart_in = 1'b0;
  logic comp_below_pfc_off_in = 1'b0, comp_above_pfc_on_in = 1'b0;
  logic comp_below_burst_in = 1'b0, pfc_switch_thermal_in = 1'b0;
  logic gate_out, line_feedforward_ground_out, pfc_supply_switch_close_out;
  logic uvlo_low_sel_out, hv_startup_on_out, quasi_resonant_option_out;
  logic low_power_out;
  logic [7:0] on_cycles = 8'h14;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  plpc_ctrl #(.PFC_DEBOUNCE(DEB)) u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .osc_tick_in(osc_tick_in), .valley_trigger_in(valley_trigger_in),
    .pwm_cmp_in(pwm_cmp_in), .ocp_cmp_in(ocp_cmp_in),
    .hard_ocp_cmp_in(hard_ocp_cmp_in), .ff_over_3v_in(ff_over_3v_in),
    .comp_low_clamp_in(comp_low_clamp_in),
    .vcc_above_uvlo_in(vcc_above_uvlo_in),
    .vcc_above_normal_in(vcc_above_normal_in),
    .vcc_below_restart_in(vcc_below_restart_in),
    .comp_below_pfc_off_in(comp_below_pfc_off_in),
    .comp_above_pfc_on_in(comp_above_pfc_on_in),
    .comp_below_burst_in(comp_below_burst_in),
    .pfc_switch_thermal_in(pfc_switch_thermal_in), .gate_out(gate_out),
    .line_feedforward_ground_out(line_feedforward_ground_out),
    .pfc_supply_switch_close_out(pfc_supply_switch_close_out),
    .uvlo_low_sel_out(uvlo_low_sel_out),
    .hv_startup_on_out(hv_startup_on_out),
    .quasi_resonant_option_out(quasi_resonant_option_out),
    .low_power_out(low_power_out)
  );

  plpc_stage_model u_stage (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .gate_in(gate_out),
    .on_cycles_in(on_cycles), .pwm_cmp_out(pwm_cmp_in)
  );

  // ============================================================
  // Clock and hang guard; run is about a thousand cycles
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test;
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_in);
      if (pready_out === 1'b1) break;
    end
    if (i == 16) n_mismatch++;
    rdata = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // Tick or valley held past the synchroniser
  task automatic pulse(input logic v);
    @(posedge clk_in);
    if (v) valley_trigger_in <= 1'b1;
    else osc_tick_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    g = gate_out;
    osc_tick_in <= 1'b0;
    valley_trigger_in <= 1'b0;
    repeat (30) @(posedge clk_in);
  endtask

  task automatic hit;
    @(posedge clk_in);
    hard_ocp_cmp_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    hard_ocp_cmp_in <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    chk(line_feedforward_ground_out, 1);
    chk(pfc_supply_switch_close_out, 1);
    rst_b_in <= 1'b1;
    apb(1'b0, `PLPC_OFS_CTRL, 0);
    chk(rdata, 1);
    apb(1'b0, 12'h010, 0);
    chk(rerr, 1);
    chk(rdata, 0);
    vcc_above_uvlo_in <= 1'b1;
    vcc_above_normal_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(line_feedforward_ground_out, 0);
    pulse(1'b0);
    chk(g, 1);
    chk(gate_out, 0);
    pulse(1'b1);
    chk(g, 0);
    apb(1'b1, `PLPC_OFS_CTRL, 3);
    pulse(1'b1);
    chk(g, 1);
    chk(quasi_resonant_option_out, 1);
    // Slow ramp so the cycle limit ends the on-time
    on_cycles <= 8'hC8;
    pulse(1'b0);
    ocp_cmp_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk(gate_out, 0);
    ocp_cmp_in <= 1'b0;
    on_cycles <= 8'h14;
    ff_over_3v_in <= 1'b1;
    pulse(1'b0);
    chk(g, 0);
    apb(1'b0, `PLPC_OFS_STATUS, 0);
    chk(rdata[8], 1);
    ff_over_3v_in <= 1'b0;
    hit;
    apb(1'b0, `PLPC_OFS_STATUS, 0);
    chk(rdata[2:1], 1);
    pulse(1'b0);
    pulse(1'b0);
    apb(1'b0, `PLPC_OFS_STATUS, 0);
    chk(rdata[2:1], 0);
    hit;
    pulse(1'b0);
    hit;
    apb(1'b0, `PLPC_OFS_STATUS, 0);
    if (rdata[3] !== 1'b1) begin
      pulse(1'b0);
      hit;
      apb(1'b0, `PLPC_OFS_STATUS, 0);
    end
    chk(rdata[3], 1);
    pulse(1'b0);
    chk(g, 0);
    chk(line_feedforward_ground_out, 1);
    apb(1'b0, `PLPC_OFS_EVENT, 0);
    chk(rdata[1:0], 3);
    apb(1'b1, `PLPC_OFS_EVENT, 7);
    apb(1'b0, `PLPC_OFS_EVENT, 0);
    chk(rdata[1:0], 0);
    vcc_above_uvlo_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    apb(1'b0, `PLPC_OFS_STATUS, 0);
    chk(rdata[3], 0);
    chk(hv_startup_on_out, 0);
    vcc_below_restart_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(hv_startup_on_out, 1);
    vcc_below_restart_in <= 1'b0;
    vcc_above_uvlo_in <= 1'b1;
    pulse(1'b0);
    chk(g, 1);
    // Light load: debounce, hysteresis, then a broken low run
    comp_below_pfc_off_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(uvlo_low_sel_out, 1);
    repeat (DEB) pulse(1'b0);
    chk(pfc_supply_switch_close_out, 1);
    pulse(1'b0);
    chk(pfc_supply_switch_close_out, 0);
    comp_below_pfc_off_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(pfc_supply_switch_close_out, 0);
    comp_above_pfc_on_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(pfc_supply_switch_close_out, 1);
    chk(uvlo_low_sel_out, 0);
    comp_above_pfc_on_in <= 1'b0;
    comp_below_pfc_off_in <= 1'b1;
    repeat (DEB) pulse(1'b0);
    comp_below_pfc_off_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    comp_below_pfc_off_in <= 1'b1;
    pulse(1'b0);
    chk(pfc_supply_switch_close_out, 1);
    comp_below_burst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk(pfc_supply_switch_close_out, 0);
    chk(low_power_out, 1);
    pulse(1'b0);
    chk(g, 0);
    comp_below_burst_in <= 1'b0;
    comp_below_pfc_off_in <= 1'b0;
    comp_above_pfc_on_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    pulse(1'b0);
    chk(g, 1);
    comp_above_pfc_on_in <= 1'b0;
    pfc_switch_thermal_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    pulse(1'b0);
    chk(g, 0);
    end_of_test;
  end
endmodule // tb_top
